// ### inc/dci_pkg.sv
// Shared constants and carrier types for the DRAM core interface
`default_nettype none
package dci_pkg;
    // Pin and array widths (eight-bit-wide organisation)
    localparam int DQ_W       = 8;
    localparam int ROW_W      = 15;
    localparam int ROW_W_X16  = 14;
    localparam int COL_W      = 10;
    localparam int BANK_W     = 3;
    localparam int NUM_BANKS  = 8;

    // Modelled storage: a small slice of each bank
    localparam int MEM_ROW_BITS = 2;
    localparam int MEM_COL_BITS = 5;
    localparam int MEM_IDX_W    = BANK_W + MEM_ROW_BITS + MEM_COL_BITS;
    localparam int MEM_WORDS    = 1 << MEM_IDX_W;

    // Burst lengths in beats, read latency in link clock rising edges
    localparam logic [3:0] BURST_FULL = 4'h8;
    localparam logic [3:0] BURST_CHOP = 4'h4;
    localparam logic [3:0] RD_LAT_CK  = 4'h5;

    // Address bit positions with a special meaning
    localparam int AUTO_PRE_BIT  = 10;
    localparam int CHOP_SEL_BIT  = 12;

    // Write data buffer
    localparam int WBUF_DEPTH = 4;

    // Refresh obligations of the controller (for reference)
    localparam int REFRESH_CMDS       = 8192;
    localparam int REFRESH_WINDOW_MS  = 64;
    localparam int REFRESH_HOT_MS     = 32;

    // Command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR  = 4'h4;
    localparam logic [3:0] CMD_RD  = 4'h5;
    localparam logic [3:0] CMD_NOP = 4'h7;

    // Command and address pins as sampled together
    typedef struct packed {
        logic              cke;
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0]  addr;
    } dci_cmd_s;

    // One captured write beat bound for the array
    typedef struct packed {
        logic [MEM_IDX_W-1:0] idx;
        logic                 mask;
        logic [DQ_W-1:0]      data;
    } dci_wr_entry_s;

    typedef enum logic [1:0] {PWR_ACTIVE, PWR_DOWN, PWR_SELF_REF} dci_pwr_e;
    typedef enum logic [1:0] {BST_IDLE, BST_WR, BST_RD_WAIT, BST_RD_DATA} dci_bst_e;
endpackage : dci_pkg
`default_nettype wire

// ### hdl/dci_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`default_nettype none
module dci_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] store_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W:0]   count_q;
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count
    assign in_ready  = (count_q != (PTR_W+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data  = store_q[rd_ptr_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Entry storage, no reset needed on data
    always_ff @(posedge ref_clk) begin
        if (push) begin
            store_q[wr_ptr_q] <= in_data;
        end
    end

    // Pointers wrap at the depth
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
            end
        end
    end

    // Occupancy
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            count_q <= '0;
        end else if (push && !pop) begin
            count_q <= count_q + 1'b1;
        end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
        end
    end
endmodule : dci_fifo
`default_nettype wire

// ### hdl/dci_core.sv
// Device-side command decode, bank tracking and burst data path of the DRAM
`default_nettype none
module dci_core (
    // Clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       sys_rst,
    // Differential link clock from the controller
    input  wire logic                       diff_clock_true,
    input  wire logic                       diff_clock_comp,
    // Command, control and address pins
    input  wire dci_pkg::dci_cmd_s          cmd_pins,
    // Burst mode straps
    input  wire logic                       per_access_burst_choice,
    input  wire logic                       fixed_chop,
    // Data pins, split into input, output and enable
    input  wire logic [dci_pkg::DQ_W-1:0]   dq_i,
    output logic [dci_pkg::DQ_W-1:0]        dq_o,
    output logic                            dq_oe,
    input  wire logic                       write_mask,
    // Data strobe pair
    input  wire logic                       dqs_true_i,
    output logic                            dqs_true_o,
    output logic                            dqs_comp_o,
    output logic                            dqs_oe,
    // Status
    output logic [dci_pkg::NUM_BANKS-1:0]   bank_open,
    output logic                            self_refresh_active,
    output logic                            power_down_active,
    output logic                            access_error,
    output logic                            write_buf_ready
);
    import dci_pkg::*;

    // Synchroniser stages
    logic          ck_t_s1_q, ck_t_s2_q, ck_c_s1_q, ck_c_s2_q, ck_prev_q;
    dci_cmd_s      cmd_s1_q, cmd_s2_q;
    logic [DQ_W-1:0] dq_s1_q, dq_s2_q;
    logic          dm_s1_q, dm_s2_q;
    logic          dqs_s1_q, dqs_s2_q, dqs_prev_q;
    logic          otf_s1_q, otf_s2_q, chop_s1_q, chop_s2_q;

    // Edge and command decode
    logic          ck_rise, ck_fall, dqs_rise, dqs_fall;
    logic          cmd_take;
    logic [3:0]    cmd_code;
    logic          is_act, is_pre, is_rd, is_wr, is_ref;
    logic          rw_ok, rw_bad;
    logic [3:0]    new_len;

    // State
    dci_pwr_e      pwr_q;
    dci_bst_e      bst_q;
    logic [3:0]    beat_q;
    logic [3:0]    len_q;
    logic [3:0]    lat_q;
    logic [COL_W-1:0]  col_q;
    logic [BANK_W-1:0] bank_q;
    logic          ap_q;
    logic [ROW_W-1:0]  open_row_q [NUM_BANKS];
    logic [NUM_BANKS-1:0] bank_open_q;
    logic          burst_done;
    logic          access_error_q;

    // Read path registers
    logic [DQ_W-1:0] dq_o_q;
    logic          dq_oe_q, dqs_t_q, dqs_oe_q;

    // Array and write buffer
    logic [DQ_W-1:0] mem [MEM_WORDS];
    logic [MEM_IDX_W-1:0] beat_idx;
    logic [COL_W-1:0] beat_col;
    dci_wr_entry_s wbuf_in, wbuf_out;
    logic          wbuf_push, wbuf_out_valid, wbuf_out_ready;
    logic          wr_beat_edge;

    // Beat column in sequential order, wrapping inside the 8 or 4 block
    function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
                                                   input logic [3:0] beat,
                                                   input logic [3:0] len);
        logic [COL_W-1:0] c;
        c = start;
        if (len == BURST_CHOP) begin
            c[1:0] = start[1:0] + beat[1:0];
        end else begin
            c[2:0] = start[2:0] + beat[2:0];
        end
        return c;
    endfunction : burst_col

    // All pin inputs pass two flops before anything reads them
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ck_t_s1_q <= 1'b0;
            ck_t_s2_q <= 1'b0;
            ck_c_s1_q <= 1'b1;
            ck_c_s2_q <= 1'b1;
            cmd_s1_q  <= '0;
            cmd_s2_q  <= '0;
            dq_s1_q   <= '0;
            dq_s2_q   <= '0;
            dm_s1_q   <= 1'b0;
            dm_s2_q   <= 1'b0;
            dqs_s1_q  <= 1'b0;
            dqs_s2_q  <= 1'b0;
            otf_s1_q  <= 1'b0;
            otf_s2_q  <= 1'b0;
            chop_s1_q <= 1'b0;
            chop_s2_q <= 1'b0;
        end else begin
            ck_t_s1_q <= diff_clock_true;
            ck_t_s2_q <= ck_t_s1_q;
            ck_c_s1_q <= diff_clock_comp;
            ck_c_s2_q <= ck_c_s1_q;
            cmd_s1_q  <= cmd_pins;
            cmd_s2_q  <= cmd_s1_q;
            dq_s1_q   <= dq_i;
            dq_s2_q   <= dq_s1_q;
            dm_s1_q   <= write_mask;
            dm_s2_q   <= dm_s1_q;
            dqs_s1_q  <= dqs_true_i;
            dqs_s2_q  <= dqs_s1_q;
            otf_s1_q  <= per_access_burst_choice;
            otf_s2_q  <= otf_s1_q;
            chop_s1_q <= fixed_chop;
            chop_s2_q <= chop_s1_q;
        end
    end

    // Previous levels for edge detection, taken only from second stages
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ck_prev_q  <= 1'b0;
            dqs_prev_q <= 1'b0;
        end else begin
            ck_prev_q  <= ck_t_s2_q;
            dqs_prev_q <= dqs_s2_q;
        end
    end

    // Positive edge needs the complement low as well; both edges move data
    assign ck_rise  = ck_t_s2_q & ~ck_prev_q & ~ck_c_s2_q;
    assign ck_fall  = ~ck_t_s2_q & ck_prev_q;
    assign dqs_rise = dqs_s2_q & ~dqs_prev_q;
    assign dqs_fall = ~dqs_s2_q & dqs_prev_q;

    // Command decode; chip select is part of the code so high gives no match
    assign cmd_take = ck_rise && (pwr_q == PWR_ACTIVE) && cmd_s2_q.cke;
    assign cmd_code = {cmd_s2_q.cs_n, cmd_s2_q.ras_n, cmd_s2_q.cas_n, cmd_s2_q.we_n};
    assign is_act   = cmd_take && (cmd_code == CMD_ACT);
    assign is_pre   = cmd_take && (cmd_code == CMD_PRE);
    assign is_rd    = cmd_take && (cmd_code == CMD_RD);
    assign is_wr    = cmd_take && (cmd_code == CMD_WR);
    assign is_ref   = ck_rise && (pwr_q == PWR_ACTIVE) && (cmd_code == CMD_REF);

    // Accesses need an idle burst engine and an open row in the bank
    assign rw_ok  = (is_rd || is_wr) && (bst_q == BST_IDLE) && bank_open_q[cmd_s2_q.bank];
    assign rw_bad = (is_rd || is_wr) && !rw_ok;

    // Per-access choice looks at the chop select bit, else the fixed strap
    always_comb begin
        if (otf_s2_q) begin
            new_len = cmd_s2_q.addr[CHOP_SEL_BIT] ? BURST_FULL : BURST_CHOP;
        end else begin
            new_len = chop_s2_q ? BURST_CHOP : BURST_FULL;
        end
    end

    // Power state: clock enable low at a rising edge with the burst engine idle enters a low-power mode
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pwr_q <= PWR_ACTIVE;
        end else if (ck_rise) begin
            unique case (pwr_q)
                PWR_ACTIVE: begin
                    if (!cmd_s2_q.cke && bst_q == BST_IDLE) begin
                        pwr_q <= is_ref ? PWR_SELF_REF : PWR_DOWN;
                    end
                end
                PWR_DOWN, PWR_SELF_REF: begin
                    if (cmd_s2_q.cke) begin
                        pwr_q <= PWR_ACTIVE;
                    end
                end
                default: pwr_q <= PWR_ACTIVE;
            endcase
        end
    end

    // Burst engine; one access at a time, later ones flagged as errors
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bst_q  <= BST_IDLE;
            beat_q <= '0;
            len_q  <= BURST_FULL;
            lat_q  <= '0;
            col_q  <= '0;
            bank_q <= '0;
            ap_q   <= 1'b0;
        end else begin
            unique case (bst_q)
                BST_IDLE: begin
                    if (rw_ok) begin
                        bank_q <= cmd_s2_q.bank;
                        col_q  <= cmd_s2_q.addr[COL_W-1:0];
                        ap_q   <= cmd_s2_q.addr[AUTO_PRE_BIT];
                        len_q  <= new_len;
                        beat_q <= '0;
                        lat_q  <= RD_LAT_CK;
                        bst_q  <= is_wr ? BST_WR : BST_RD_WAIT;
                    end
                end
                BST_WR: begin
                    if (wr_beat_edge) begin
                        if (beat_q == len_q - 4'h1) begin
                            bst_q <= BST_IDLE;
                        end
                        beat_q <= beat_q + 4'h1;
                    end
                end
                BST_RD_WAIT: begin
                    if (ck_rise) begin
                        lat_q <= lat_q - 4'h1;
                        if (lat_q == 4'h1) begin
                            bst_q  <= BST_RD_DATA;
                            beat_q <= 4'h1;
                        end
                    end
                end
                BST_RD_DATA: begin
                    if (ck_rise || ck_fall) begin
                        if (beat_q == len_q) begin
                            bst_q <= BST_IDLE;
                        end else begin
                            beat_q <= beat_q + 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // End of burst, used to start the self-timed precharge
    assign burst_done = ((bst_q == BST_WR) && wr_beat_edge && (beat_q == len_q - 4'h1)) ||
                        ((bst_q == BST_RD_DATA) && (ck_rise || ck_fall) && (beat_q == len_q));

    // Bank table: eight banks kept apart, each with its own open row
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bank_open_q <= '0;
            for (int b = 0; b < NUM_BANKS; b++) begin
                open_row_q[b] <= '0;
            end
        end else begin
            if (burst_done && ap_q) begin
                bank_open_q[bank_q] <= 1'b0;
            end
            if (is_act) begin
                bank_open_q[cmd_s2_q.bank] <= 1'b1;
                open_row_q[cmd_s2_q.bank]  <= cmd_s2_q.addr;
            end else if (is_pre) begin
                if (cmd_s2_q.addr[AUTO_PRE_BIT]) begin
                    bank_open_q <= '0;
                end else begin
                    bank_open_q[cmd_s2_q.bank] <= 1'b0;
                end
            end
        end
    end

    // One-cycle pulse for a read or write refused for a closed bank or busy engine
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            access_error_q <= 1'b0;
        end else begin
            access_error_q <= rw_bad;
        end
    end

    // Array index of the current beat within the modelled slice
    assign beat_col = burst_col(col_q, beat_q, len_q);
    assign beat_idx = {bank_q, open_row_q[bank_q][MEM_ROW_BITS-1:0], beat_col[MEM_COL_BITS-1:0]};

    // First write beat on the first rising strobe, then alternate edges
    assign wr_beat_edge = (bst_q == BST_WR) && (beat_q[0] ? dqs_fall : dqs_rise);
    assign wbuf_push    = wr_beat_edge;
    assign wbuf_in      = '{idx: beat_idx, mask: dm_s2_q, data: dq_s2_q};

    // Draining stalls while a read burst streams out of the array
    assign wbuf_out_ready = (bst_q != BST_RD_DATA);

    dci_fifo #(
        .WIDTH ($bits(dci_wr_entry_s)),
        .DEPTH (WBUF_DEPTH)
    ) u_wbuf (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .in_valid  (wbuf_push),
        .in_ready  (write_buf_ready),
        .in_data   (wbuf_in),
        .out_valid (wbuf_out_valid),
        .out_ready (wbuf_out_ready),
        .out_data  (wbuf_out)
    );

    // Array write; a masked beat never reaches the cells
    always_ff @(posedge ref_clk) begin
        if (wbuf_out_valid && wbuf_out_ready && !wbuf_out.mask) begin
            mem[wbuf_out.idx] <= wbuf_out.data;
        end
    end

    // Read driver: one clock of preamble, then data and strobe change together
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dq_o_q   <= '0;
            dq_oe_q  <= 1'b0;
            dqs_t_q  <= 1'b0;
            dqs_oe_q <= 1'b0;
        end else begin
            unique case (bst_q)
                BST_RD_WAIT: begin
                    if (ck_rise && lat_q == 4'h2) begin
                        dqs_oe_q <= 1'b1;
                        dqs_t_q  <= 1'b0;
                    end else if (ck_rise && lat_q == 4'h1) begin
                        dq_o_q  <= mem[beat_idx];
                        dq_oe_q <= 1'b1;
                        dqs_t_q <= 1'b1;
                    end
                end
                BST_RD_DATA: begin
                    if (ck_rise || ck_fall) begin
                        if (beat_q == len_q) begin
                            dq_oe_q  <= 1'b0;
                            dqs_oe_q <= 1'b0;
                            dqs_t_q  <= 1'b0;
                        end else begin
                            dq_o_q  <= mem[beat_idx];
                            dqs_t_q <= ~dqs_t_q;
                        end
                    end
                end
                default: begin
                    dq_oe_q  <= 1'b0;
                    dqs_oe_q <= 1'b0;
                    dqs_t_q  <= 1'b0;
                end
            endcase
        end
    end

    // Refresh commands keep the cells by themselves here; nothing to count
    // since the controller owns the refresh rate (is_ref only selects self refresh entry)

    // Outputs
    assign dq_o                = dq_o_q;
    assign dq_oe               = dq_oe_q;
    assign dqs_true_o          = dqs_t_q;
    assign dqs_comp_o          = ~dqs_t_q;
    assign dqs_oe              = dqs_oe_q;
    assign bank_open           = bank_open_q;
    assign self_refresh_active = (pwr_q == PWR_SELF_REF);
    assign power_down_active   = (pwr_q == PWR_DOWN);
    assign access_error        = access_error_q;
endmodule : dci_core
`default_nettype wire

// ### test/dci_ctrl_model.sv
// Controller model: free-running link clock, command pins and write lane
`default_nettype none
module dci_ctrl_model
    import dci_pkg::*;
#(
    parameter int GAP_CK = 1
) (
    // Link clock pair
    output logic            ck_t,
    output logic            ck_c,
    // Command pins and write lane
    output dci_cmd_s        cmd,
    output logic [DQ_W-1:0] dq,
    output logic            dm,
    output logic            dqs
);
    timeunit 1ns;
    timeprecision 100ps;
    // Link clock, 160 ns period, phase unrelated to the system clock
    initial begin
        ck_t = 1'b0;
        #37;
        forever #80 ck_t = ~ck_t;
    end
    assign ck_c = ~ck_t;
    // Idle lane: strobe low, selected NOP
    initial begin
        cmd = {1'b1, CMD_NOP, 3'h0, 15'h0};
        dq  = 8'h00;
        dm  = 1'b0;
        dqs = 1'b0;
    end
    // Pins held across one link rise, then scrambled so no stale command lingers
    task automatic send(input logic [3:0] c, input logic [2:0] ba, input logic [14:0] a, input logic cke);
        @(negedge ck_t);
        cmd = {cke, c, ba, a};
        @(negedge ck_t);
        cmd = {cke, CMD_NOP, ~ba, ~a};
        repeat (GAP_CK) @(negedge ck_t);
    endtask : send
    // Write burst: a low strobe preamble, then edges centred in each beat
    task automatic burst(input logic [63:0] d, input logic [7:0] m, input int n);
        @(negedge ck_t);
        for (int i = 0; i < n; i++) begin
            dq = d[8*i+:8];
            dm = m[i];
            #40 dqs = ~dqs;
            #40;
        end
        dq = ~dq;
        dm = ~dm;
    endtask : burst
endmodule : dci_ctrl_model
`default_nettype wire

// ### test/dci_core_checker.sv
// Port-level assertions for the DRAM core interface
`default_nettype none
module dci_core_checker (
    // Clock and reset
    input wire logic                         ref_clk,
    input wire logic                         sys_rst,
    // Read lane
    input wire logic [dci_pkg::DQ_W-1:0]     dq_o,
    input wire logic                         dq_oe,
    input wire logic                         dqs_true_o,
    input wire logic                         dqs_comp_o,
    input wire logic                         dqs_oe,
    // Status
    input wire logic [dci_pkg::NUM_BANKS-1:0] bank_open,
    input wire logic                         self_refresh_active,
    input wire logic                         power_down_active,
    input wire logic                         access_error
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic [3:0] edge_q;
    // Strobe edges of one read burst, opening rise included
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !dq_oe) edge_q <= 4'h0;
        else if (!$past(dq_oe) || $changed(dqs_true_o)) edge_q <= edge_q + 4'h1;
    end
    sequence preamble_s;
        dqs_oe && !dqs_true_o && !dq_oe;
    endsequence
    sequence first_beat_s;
        $rose(dq_oe) && dqs_true_o;
    endsequence
    chk_strobe_pair: assert property (dqs_comp_o == !dqs_true_o)
        else $error("strobe pair not complementary");
    chk_first_beat: assert property (preamble_s [*8] ##1 !(dqs_oe && !dqs_true_o && !dq_oe) |-> first_beat_s)
        else $error("first read beat not on strobe rise after preamble");
    chk_data_on_edge: assert property (dq_oe && $past(dq_oe) && $changed(dq_o) |-> $changed(dqs_true_o))
        else $error("read data moved without a strobe edge");
    chk_oe_pair: assert property (dq_oe |-> dqs_oe)
        else $error("data driven without strobe");
    chk_beat_count: assert property ($fell(dq_oe) |-> edge_q == 4'h8 || edge_q == 4'h4)
        else $error("read burst beat count wrong");
    chk_beat_hold: assert property (dq_oe && $changed(dqs_true_o) |=> $stable(dqs_true_o) [*5])
        else $error("read beat shorter than half a link clock");
    chk_err_single: assert property (access_error |=> !access_error)
        else $error("refusal flag longer than one cycle");
    chk_low_power_quiet: assert property ((self_refresh_active || power_down_active)
        |-> !dq_oe && !dqs_oe && !(self_refresh_active && power_down_active))
        else $error("lane active in a low power state");
    chk_reset_state: assert property ($fell(sys_rst) |-> bank_open == '0 && !dq_oe && !access_error)
        else $error("state not cleared by reset");
endmodule : dci_core_checker
bind dci_core dci_core_checker chk_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .dq_o(dq_o), .dq_oe(dq_oe),
    .dqs_true_o(dqs_true_o), .dqs_comp_o(dqs_comp_o), .dqs_oe(dqs_oe), .bank_open(bank_open),
    .self_refresh_active(self_refresh_active), .power_down_active(power_down_active),
    .access_error(access_error));
`default_nettype wire

// ### test/tb_dci_core.sv
// Self-checking bench for the DRAM core interface
`default_nettype none
module tb_dci_core;
    import dci_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, sys_rst, diff_clock_true, diff_clock_comp, per_access_burst_choice, write_mask, err_seen;
    logic dq_oe, dqs_true_i, dqs_true_o, dqs_comp_o, dqs_oe, dqs_w, access_error, write_buf_ready;
    logic self_refresh_active, power_down_active, fixed_chop;
    logic [7:0] dq_i, dq_o, dq_w, bank_open;
    dci_cmd_s   cmd_pins;
    int error_cnt = 0;
    int total_checks = 0;
    // Shared pins resolve to whoever has its enable up
    assign dq_i       = dq_oe ? dq_o : dq_w;
    assign dqs_true_i = dqs_oe ? dqs_true_o : dqs_w;
    dci_core dut_u (.ref_clk, .sys_rst, .diff_clock_true, .diff_clock_comp, .cmd_pins,
        .per_access_burst_choice, .fixed_chop, .dq_i, .dq_o, .dq_oe, .write_mask, .dqs_true_i,
        .dqs_true_o, .dqs_comp_o, .dqs_oe, .bank_open, .self_refresh_active, .power_down_active,
        .access_error, .write_buf_ready);
    dci_ctrl_model ctrl_u (.ck_t(diff_clock_true), .ck_c(diff_clock_comp), .cmd(cmd_pins),
        .dq(dq_w), .dm(write_mask), .dqs(dqs_w));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Refusal pulse lasts one cycle, so latch it
    always @(posedge ref_clk) if (access_error === 1'b1) err_seen <= 1'b1;
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    function automatic logic [14:0] ca(input logic bl8, input logic ap, input logic [9:0] col);
        return {2'b00, bl8, 1'b0, ap, col};
    endfunction : ca
    // Collect one beat per strobe edge while the device drives the lane
    task automatic rd_check(input logic [63:0] exp, input int n);
        logic [63:0] got;
        logic        last;
        int          k;
        got = '0;
        last = 1'b0;
        k = 0;
        for (int c = 0; c < 400 && k < n; c++) begin
            @(posedge ref_clk);
            #1;
            if (dq_oe === 1'b1 && dqs_true_o !== last) begin
                got[8*k+:8] = dq_o;
                last = dqs_true_o;
                k++;
            end
        end
        chk(got, exp);
    endtask : rd_check
    // Open a row; a deselected activate must leave banks alone
    task automatic t_open;
        ctrl_u.send(CMD_ACT, 3'h2, 15'h0001, 1'b1);
        chk(bank_open, 8'h04);
        ctrl_u.send({1'b1, CMD_ACT[2:0]}, 3'h5, 15'h0001, 1'b1);
        chk(bank_open, 8'h04);
    endtask : t_open
    // Read of a closed bank is refused
    task automatic t_refuse;
        err_seen = 1'b0;
        ctrl_u.send(CMD_RD, 3'h3, ca(1'b1, 1'b0, 10'h000), 1'b1);
        chk(err_seen, 1'b1);
    endtask : t_refuse
    // Full write, masked chopped overwrite, wrapped reads, auto precharge
    task automatic t_burst;
        ctrl_u.send(CMD_WR, 3'h2, ca(1'b1, 1'b0, 10'h008), 1'b1);
        ctrl_u.burst(64'h1716151413121110, 8'h00, 8);
        ctrl_u.send(CMD_WR, 3'h2, ca(1'b0, 1'b0, 10'h008), 1'b1);
        ctrl_u.burst(64'h53525150, 8'h02, 4);
        repeat (40) @(negedge ref_clk);
        ctrl_u.send(CMD_RD, 3'h2, ca(1'b1, 1'b0, 10'h00d), 1'b1);
        rd_check(64'h1453521150171615, 8);
        // Strap mode: chop select ignored, the fixed strap asks for four beats
        @(negedge ref_clk);
        per_access_burst_choice = 1'b0;
        fixed_chop = 1'b1;
        ctrl_u.send(CMD_RD, 3'h2, ca(1'b1, 1'b1, 10'h00e), 1'b1);
        rd_check(64'h15141716, 4);
        repeat (40) @(negedge ref_clk);
        per_access_burst_choice = 1'b1;
        fixed_chop = 1'b0;
        chk(bank_open, 8'h00);
    endtask : t_burst
    // Single-bank and all-bank precharge
    task automatic t_close;
        ctrl_u.send(CMD_ACT, 3'h0, 15'h0002, 1'b1);
        ctrl_u.send(CMD_ACT, 3'h7, 15'h7fff, 1'b1);
        chk(bank_open, 8'h81);
        ctrl_u.send(CMD_PRE, 3'h0, 15'h0000, 1'b1);
        chk(bank_open, 8'h80);
        ctrl_u.send(CMD_PRE, 3'h0, 15'h0400, 1'b1);
        chk(bank_open, 8'h00);
    endtask : t_close
    // Power-down and self refresh entry and exit
    task automatic t_power;
        ctrl_u.send(CMD_NOP, 3'h0, 15'h0000, 1'b0);
        chk({self_refresh_active, power_down_active}, 2'b01);
        ctrl_u.send(CMD_NOP, 3'h0, 15'h0000, 1'b1);
        ctrl_u.send(CMD_REF, 3'h0, 15'h0000, 1'b1);
        chk({self_refresh_active, power_down_active, bank_open}, 10'h000);
        ctrl_u.send(CMD_REF, 3'h0, 15'h0000, 1'b0);
        chk({self_refresh_active, power_down_active}, 2'b10);
        ctrl_u.send(CMD_NOP, 3'h0, 15'h0000, 1'b1);
        chk({self_refresh_active, power_down_active}, 2'b00);
    endtask : t_power
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        per_access_burst_choice = 1'b1;
        fixed_chop = 1'b0;
        err_seen = 1'b0;
        repeat (20) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk({dqs_comp_o, write_buf_ready, dq_oe, bank_open}, {3'b110, 8'h00});
        t_open();
        t_refuse();
        t_burst();
        t_close();
        t_power();
        test_done();
    end
    // Watchdog at 2500 link clocks, well beyond the hundred or so the tests need
    initial begin
        #400000;
        error_cnt++;
        test_done();
    end
endmodule : tb_dci_core
`default_nettype wire
